// ---- shared/fpu_host_defines.svh ----
// Constants of the coprocessor host port: command fields, status layout.
// Assumes inclusion by bare name from any file that needs these values.
//
// Overview of operation
// - Reset aborts work, clears status and reinitializes the operand stack pointer.
// - After reset the done, fault and service outputs are low.
// - Select line and strobe choose push, pop, command entry or status read.
// - Transfers without chip select low are ignored.
// - Both strobes high and chip select low drive the wait handshake low.
// - Write starts on store strobe falling; wait rises to accept; host holds.
// - Read starts on read strobe falling; wait rises with data held while low.
// - Chip select held low keeps wait low until the next transfer.
// - Transfers may start anytime; wait stretches them and the host obeys it.
// - With done acknowledge tied low, command done is a short pulse.
// - Any selected read clears command done at the read strobe falling edge.
// - Any selected write clears command done at the store strobe rising edge.
// - Service request rises at completion only if the command enabled it.
// - Service acknowledge low or reset drives service request low.
// - Service acknowledge held low suppresses setting of service request.
// - Bus bit 0 is least significant, bit 7 most; high means one.
// - Operands enter least significant first; results leave most significant first.
// - Divide by zero, exponent overflow or underflow raise the fault flag.
// - A selected status read or reset clears the fault flag.
// - Errors may rise mid-command; a status read clears the error bits.
// - Command bit 7 enables service; the low seven bits select the operation.
// - A command written during execution waits until execution ends.
`ifndef FPU_HOST_DEFINES_SVH
`define FPU_HOST_DEFINES_SVH

// ------------------------------------------------------------
// Bus and command layout
// ------------------------------------------------------------
`define BUS_W 8
`define CMD_SVC_BIT 7
`define CMD_OP_W 7

// ------------------------------------------------------------
// Status byte layout
// ------------------------------------------------------------
`define ST_DIV0_BIT 0
`define ST_OVF_BIT 1
`define ST_UNF_BIT 2
`define ST_CORE_LSB 3
`define ST_CORE_W 4
`define ST_BUSY_BIT 7
`define ERR_W 3
`define ERR_RESET 3'h0

`endif

// ---- shared/fpu_host_pkg.sv ----
// Types shared by the host port, its checker, core model and bench.
// Assumes the constants header sits in the include path.
`include "fpu_host_defines.svh"

package fpu_host_pkg;

  typedef logic [`BUS_W-1:0] byte_t;
  typedef logic [`CMD_OP_W-1:0] opcode_t;
  typedef logic [`ERR_W-1:0] err_t;
  typedef logic [`ST_CORE_W-1:0] core_flags_t;

  // Host transfer sequencer states.
  typedef enum logic [2:0] {
    XF_IDLE,
    XF_WR_HOLD,
    XF_WR_ACK,
    XF_RD_FETCH,
    XF_RD_ACK
  } xfer_state_t;

endpackage

// ---- shared/byte_stream_if.sv ----
// Valid/ready byte stream between the host port and its buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps

interface byte_stream_if #(
  parameter int WIDTH = 8
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- design/byte_skid_buffer.sv ----
// Two-entry buffer between a byte source and a stalling sink.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/10ps

module byte_skid_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  byte_stream_if.snk in_s,
  byte_stream_if.src out_s
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic rd_ptr_q;
  logic wr_ptr_q;
  logic [1:0] count_q;
  logic push;
  logic pop;

  // Refuse shapes that the one-bit pointers cannot serve.
  initial begin
    if (DEPTH != 2 || WIDTH < 1) begin
      $error("byte_skid_buffer needs DEPTH 2 and WIDTH at least 1");
    end
  end

  // Handshakes come straight from the fill count.
  assign in_s.ready = (count_q != 2'h2);
  assign out_s.valid = (count_q != 2'h0);
  assign out_s.data = mem_q[rd_ptr_q];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  // Pointers and fill count move with each accepted word.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // Words are written without reset; the count guards them.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_s.data;
    end
  end

endmodule // byte_skid_buffer

// ---- design/fpu_host_bus_interface.sv ----
// Host bus port of a stack floating-point coprocessor.
// Assumes host pins are asynchronous to ref_clk_i and the core shares it.
`timescale 1ns/10ps
`include "fpu_host_defines.svh"

module fpu_host_bus_interface (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Host pins.
  input wire logic chip_select_n_i,
  input wire logic read_strobe_n_i,
  input wire logic store_strobe_n_i,
  input wire logic cmd_data_sel_i,
  input wire fpu_host_pkg::byte_t host_bus_i,
  output fpu_host_pkg::byte_t host_bus_o,
  output logic host_bus_oe_o,
  output logic wait_handshake_o,
  output logic command_done_o,
  input wire logic done_ack_n_i,
  output logic service_request_o,
  input wire logic service_ack_n_i,
  output logic fault_flag_o,
  // Execution core side.
  output logic core_start_o,
  output fpu_host_pkg::opcode_t core_opcode_o,
  input wire logic core_done_i,
  input wire fpu_host_pkg::err_t core_err_i,
  input wire fpu_host_pkg::core_flags_t core_flags_i,
  output logic push_valid_o,
  output fpu_host_pkg::byte_t push_data_o,
  input wire logic push_ready_i,
  input wire logic pop_valid_i,
  input wire fpu_host_pkg::byte_t pop_data_i,
  output logic pop_ready_o
);
  import fpu_host_pkg::*;

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------

  // A one-to-zero step between the previous and present sample.
  function automatic logic fell(input logic prev, input logic cur);
    fell = prev && !cur;
  endfunction

  // A zero-to-one step between the previous and present sample.
  function automatic logic rose(input logic prev, input logic cur);
    rose = !prev && cur;
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [3:0] ctl_meta_q;
  logic [3:0] ctl_sync_q;
  logic [3:0] ctl_prev_q;
  byte_t bus_meta_q;
  byte_t bus_sync_q;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic cd;
  logic rd_n_prev;
  logic wr_n_prev;

  // Every host pin passes two flops before any logic looks at it.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl_meta_q <= 4'hf;
      ctl_sync_q <= 4'hf;
      ctl_prev_q <= 4'hf;
    end else begin
      ctl_meta_q <= {cmd_data_sel_i, store_strobe_n_i, read_strobe_n_i,
                     chip_select_n_i};
      ctl_sync_q <= ctl_meta_q;
      ctl_prev_q <= ctl_sync_q;
    end
  end

  // Write data is synchronised alongside the strobes.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_meta_q <= 8'h00;
      bus_sync_q <= 8'h00;
    end else begin
      bus_meta_q <= host_bus_i;
      bus_sync_q <= bus_meta_q;
    end
  end

  assign cs_n = ctl_sync_q[0];
  assign rd_n = ctl_sync_q[1];
  assign wr_n = ctl_sync_q[2];
  assign cd = ctl_sync_q[3];
  assign rd_n_prev = ctl_prev_q[1];
  assign wr_n_prev = ctl_prev_q[2];

  // ------------------------------------------------------------
  // Transfer decode
  // ------------------------------------------------------------
  logic wr_start;
  logic rd_start;
  logic wr_end;

  // A transfer only counts while chip select is low.
  assign wr_start = !cs_n && fell(wr_n_prev, wr_n) && rd_n;
  assign rd_start = !cs_n && fell(rd_n_prev, rd_n) && wr_n;
  assign wr_end = !cs_n && rose(wr_n_prev, wr_n);

  // ------------------------------------------------------------
  // Push path buffer
  // ------------------------------------------------------------
  byte_stream_if #(.WIDTH(`BUS_W)) push_in ();
  byte_stream_if #(.WIDTH(`BUS_W)) push_out ();

  byte_skid_buffer #(
    .WIDTH(`BUS_W),
    .DEPTH(2)
  ) u_push_buf (
    .clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .in_s(push_in.snk),
    .out_s(push_out.src)
  );

  // Bytes leave in arrival order, least significant first.
  assign push_valid_o = push_out.valid;
  assign push_data_o = push_out.data;
  assign push_out.ready = push_ready_i;

  // ------------------------------------------------------------
  // Transfer sequencer
  // ------------------------------------------------------------
  xfer_state_t state_q;
  logic hold_cd_q;
  byte_t wr_data_q;
  byte_t rd_data_q;
  logic oe_q;
  logic busy_q;
  logic svc_en_q;
  logic start_q;
  opcode_t opcode_q;
  logic cmd_ok;
  logic push_ok;
  err_t err_q;
  byte_t status_byte;

  // A command waits for the running one; a push waits for buffer room.
  assign cmd_ok = hold_cd_q && !busy_q;
  assign push_ok = !hold_cd_q && push_in.ready;
  assign push_in.valid = (state_q == XF_WR_HOLD) && push_ok;
  assign push_in.data = wr_data_q;
  assign pop_ready_o = (state_q == XF_RD_FETCH) && !hold_cd_q;

  // Status byte shows busy, core flags and sticky error bits.
  always_comb begin
    status_byte = 8'h00;
    status_byte[`ST_BUSY_BIT] = busy_q;
    status_byte[`ST_CORE_LSB +: `ST_CORE_W] = core_flags_i;
    status_byte[`ST_DIV0_BIT +: `ERR_W] = err_q;
  end

  // The sequencer walks each host transfer to its acknowledge.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= XF_IDLE;
      hold_cd_q <= 1'b0;
      wr_data_q <= 8'h00;
    end else begin
      case (state_q)
        XF_IDLE: begin
          if (wr_start) begin
            hold_cd_q <= cd;
            wr_data_q <= bus_sync_q;
            state_q <= XF_WR_HOLD;
          end else if (rd_start) begin
            hold_cd_q <= cd;
            state_q <= cd ? XF_RD_ACK : XF_RD_FETCH;
          end
        end
        XF_WR_HOLD: begin
          if (cmd_ok || push_ok) begin
            state_q <= XF_WR_ACK;
          end
        end
        XF_WR_ACK: begin
          if (wr_n) begin
            state_q <= XF_IDLE;
          end
        end
        XF_RD_FETCH: begin
          if (pop_valid_i) begin
            state_q <= XF_RD_ACK;
          end
        end
        XF_RD_ACK: begin
          if (rd_n) begin
            state_q <= XF_IDLE;
          end
        end
        default: begin
          state_q <= XF_IDLE;
        end
      endcase
    end
  end

  // Read data is captured once and held while the strobe stays low.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_data_q <= 8'h00;
      oe_q <= 1'b0;
    end else begin
      if (state_q == XF_IDLE && rd_start && cd) begin
        rd_data_q <= status_byte;
        oe_q <= 1'b1;
      end else if (state_q == XF_RD_FETCH && pop_valid_i) begin
        rd_data_q <= pop_data_i;
        oe_q <= 1'b1;
      end else if (state_q == XF_RD_ACK && rd_n) begin
        oe_q <= 1'b0;
      end
    end
  end

  assign host_bus_o = rd_data_q;
  assign host_bus_oe_o = oe_q;

  // ------------------------------------------------------------
  // Wait handshake
  // ------------------------------------------------------------

  // Low whenever selected and not acknowledging; high once accepted.
  always_comb begin
    wait_handshake_o = 1'b1;
    if (!cs_n) begin
      wait_handshake_o = 1'b0;
    end
    if (state_q == XF_WR_ACK || state_q == XF_RD_ACK) begin
      wait_handshake_o = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Command issue to the core
  // ------------------------------------------------------------

  // A start pulse carries the opcode; bit 7 is kept as the service enable.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      start_q <= 1'b0;
      opcode_q <= 7'h00;
      svc_en_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (state_q == XF_WR_HOLD && cmd_ok) begin
        start_q <= 1'b1;
        opcode_q <= wr_data_q[`CMD_OP_W-1:0];
        svc_en_q <= wr_data_q[`CMD_SVC_BIT];
      end
    end
  end

  // Busy spans from the start pulse to the core's completion.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_q <= 1'b0;
    end else if (state_q == XF_WR_HOLD && cmd_ok) begin
      busy_q <= 1'b1;
    end else if (core_done_i) begin
      busy_q <= 1'b0;
    end
  end

  assign core_start_o = start_q;
  assign core_opcode_o = opcode_q;

  // ------------------------------------------------------------
  // Host flags
  // ------------------------------------------------------------
  logic done_q;
  logic svc_q;
  logic fault_q;
  logic status_rd;
  logic ack_done_n;
  logic ack_svc_n;
  logic err_hit;

  assign status_rd = rd_start && cd;
  assign err_hit = |core_err_i;

  // Acknowledge pins are synchronised like every other pin.
  logic [1:0] ack_meta_q;
  logic [1:0] ack_sync_q;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_meta_q <= 2'h3;
      ack_sync_q <= 2'h3;
    end else begin
      ack_meta_q <= {service_ack_n_i, done_ack_n_i};
      ack_sync_q <= ack_meta_q;
    end
  end
  assign ack_done_n = ack_sync_q[0];
  assign ack_svc_n = ack_sync_q[1];

  // Done sets on completion; ack, reads and writes clear it, set wins.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      done_q <= 1'b0;
    end else if (busy_q && core_done_i) begin
      done_q <= 1'b1;
    end else if (!ack_done_n) begin
      done_q <= 1'b0;
    end else if (rd_start) begin
      done_q <= 1'b0;
    end else if (wr_end && state_q == XF_WR_ACK) begin
      done_q <= 1'b0;
    end
  end

  // Service request needs the enable bit; a low ack blocks setting.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      svc_q <= 1'b0;
    end else if (!ack_svc_n) begin
      svc_q <= 1'b0;
    end else if (busy_q && core_done_i && svc_en_q) begin
      svc_q <= 1'b1;
    end
  end

  // Error bits collect mid-command; a status read clears them.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      err_q <= `ERR_RESET;
    end else if (err_hit) begin
      err_q <= err_q | core_err_i;
    end else if (status_rd) begin
      err_q <= `ERR_RESET;
    end
  end

  // Fault follows any error event until a status read.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fault_q <= 1'b0;
    end else if (err_hit) begin
      fault_q <= 1'b1;
    end else if (status_rd) begin
      fault_q <= 1'b0;
    end
  end

  assign command_done_o = done_q;
  assign service_request_o = svc_q;
  assign fault_flag_o = fault_q;

endmodule // fpu_host_bus_interface

// ---- sim/fpu_host_chk.sv ----
// Assertion checker for the coprocessor host port.
// Assumes it is bound to the port's top module and sees only its pins.
`timescale 1ns/10ps

module fpu_host_chk (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic chip_select_n_i,
  input wire logic read_strobe_n_i,
  input wire logic store_strobe_n_i,
  input wire fpu_host_pkg::byte_t host_bus_o,
  input wire logic host_bus_oe_o,
  input wire logic wait_handshake_o,
  input wire logic command_done_o,
  input wire logic done_ack_n_i,
  input wire logic service_request_o,
  input wire logic service_ack_n_i,
  input wire logic fault_flag_o,
  input wire logic core_start_o,
  input wire logic core_done_i,
  input wire fpu_host_pkg::err_t core_err_i
);
  import fpu_host_pkg::*;
  // ----------------------------------------
  // Pin relations
  // ----------------------------------------
  // All checks share the one clock and its reset.
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  a_reset_flags_low: assert property ($rose(resetn_i) |-> !command_done_o &&
    !fault_flag_o && !service_request_o) else $error("flag high after reset");
  a_cs_high_quiet: assert property (chip_select_n_i [*6] |-> !core_start_o)
    else $error("command started without chip select");
  a_cs_high_wait: assert property (chip_select_n_i [*4] |-> wait_handshake_o)
    else $error("wait low while deselected");
  a_idle_wait_low: assert property ((!chip_select_n_i && read_strobe_n_i &&
    store_strobe_n_i) [*6] |-> !wait_handshake_o) else $error("wait high while idle");
  a_read_data_hold: assert property (!chip_select_n_i && !read_strobe_n_i &&
    wait_handshake_o && host_bus_oe_o |=> host_bus_oe_o && $stable(host_bus_o))
    else $error("read data not held");
  a_done_short_pulse: assert property ((!done_ack_n_i) [*5] ##1 command_done_o
    |=> !command_done_o) else $error("done not a pulse");
  a_svc_ack_clears: assert property ((!service_ack_n_i) [*5] |->
    !service_request_o) else $error("service request while acknowledged");
  a_done_on_core: assert property (core_done_i |=> command_done_o)
    else $error("done missing after completion");
  a_fault_on_err: assert property (|core_err_i |=> fault_flag_o)
    else $error("fault missing after error");

  c_start: cover property (core_start_o);
  c_service: cover property (service_request_o);
  c_fault: cover property (fault_flag_o);
endmodule // fpu_host_chk

bind fpu_host_bus_interface fpu_host_chk chk_u (.ref_clk_i, .resetn_i, .chip_select_n_i,
  .read_strobe_n_i, .store_strobe_n_i, .host_bus_o, .host_bus_oe_o, .wait_handshake_o,
  .command_done_o, .done_ack_n_i, .service_request_o, .service_ack_n_i, .fault_flag_o,
  .core_start_o, .core_done_i, .core_err_i);

// ---- sim/fpu_core_model.sv ----
// Behavioural execution core: a byte stack and a timed command runner.
// Assumes the port's clock and reset; the bench picks errors and stalls.
`timescale 1ns/10ps

module fpu_core_model #(
  parameter int EXEC_CYCLES = 20
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic stall_i,
  input wire fpu_host_pkg::err_t err_sel_i,
  input wire logic start_i,
  output logic done_o,
  output fpu_host_pkg::err_t err_o,
  input wire logic push_valid_i,
  input wire fpu_host_pkg::byte_t push_data_i,
  output logic push_ready_o,
  output logic pop_valid_o,
  output fpu_host_pkg::byte_t pop_data_o,
  input wire logic pop_ready_i,
  output logic overlap_o,
  output int depth_o
);
  import fpu_host_pkg::*;
  byte_t mem_q [16];
  int cnt_q;

  // Stalls refuse pushes; an empty stack shows a changed value, not stale data.
  assign push_ready_o = !stall_i;
  assign pop_valid_o = depth_o > 0;
  assign pop_data_o = pop_valid_o ? mem_q[depth_o - 1] : ~mem_q[0];

  // Last in, first out, so bytes pushed low first come back high first.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      depth_o <= 0;
    end else if (push_valid_i && push_ready_o) begin
      mem_q[depth_o] <= push_data_i;
      depth_o <= depth_o + 1;
    end else if (pop_valid_o && pop_ready_i) begin
      depth_o <= depth_o - 1;
    end
  end

  // Runs a command for a fixed time and notes a start that arrives while busy.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= 0;
      overlap_o <= 1'b0;
    end else if (start_i) begin
      overlap_o <= overlap_o | (cnt_q > 1);
      cnt_q <= EXEC_CYCLES;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
    end
  end

  // Completion and its error bits last one cycle.
  assign done_o = cnt_q == 1;
  assign err_o = done_o ? err_sel_i : 3'h0;
endmodule // fpu_core_model

// ---- sim/fpu_host_bus_interface_tb_top.sv ----
// Self-checking bench for the coprocessor host port with a core model.
// Assumes the shared files, the design and the checker compile first.
`timescale 1ns/10ps

module fpu_host_bus_interface_tb_top;
  import fpu_host_pkg::*;
  typedef struct packed {logic cd; logic rd; byte_t d; byte_t exp;} row_t;
  logic ref_clk_i, resetn_i, chip_select_n_i, read_strobe_n_i, store_strobe_n_i;
  logic cmd_data_sel_i, host_bus_oe_o, wait_handshake_o, command_done_o, done_ack_n_i;
  logic service_request_o, service_ack_n_i, fault_flag_o, core_start_o, core_done_i;
  logic push_valid_o, push_ready_i, pop_valid_i, pop_ready_o, stall, overlap;
  byte_t host_bus_i, host_bus_o, push_data_o, pop_data_i, q;
  opcode_t core_opcode_o;
  err_t core_err_i, err_sel;
  core_flags_t core_flags_i;
  int depth, n_mismatch, n_tests, k;
  row_t rows [9] = '{'{1'b0, 1'b0, 8'h11, 8'h00}, '{1'b0, 1'b0, 8'h22, 8'h00},
    '{1'b0, 1'b0, 8'h33, 8'h00}, '{1'b0, 1'b0, 8'h44, 8'h00}, '{1'b0, 1'b1, 8'h00, 8'h44},
    '{1'b0, 1'b1, 8'h00, 8'h33}, '{1'b0, 1'b1, 8'h00, 8'h22}, '{1'b0, 1'b1, 8'h00, 8'h11},
    '{1'b1, 1'b1, 8'h00, 8'h28}};

  assign core_flags_i = 4'h5;

  fpu_host_bus_interface dut_u (.ref_clk_i, .resetn_i, .chip_select_n_i, .read_strobe_n_i,
    .store_strobe_n_i, .cmd_data_sel_i, .host_bus_i, .host_bus_o, .host_bus_oe_o,
    .wait_handshake_o, .command_done_o, .done_ack_n_i, .service_request_o,
    .service_ack_n_i, .fault_flag_o, .core_start_o, .core_opcode_o, .core_done_i,
    .core_err_i, .core_flags_i, .push_valid_o, .push_data_o, .push_ready_i, .pop_valid_i,
    .pop_data_i, .pop_ready_o);

  fpu_core_model core_u (.clk_i(ref_clk_i), .resetn_i, .stall_i(stall), .err_sel_i(err_sel),
    .start_i(core_start_o), .done_o(core_done_i), .err_o(core_err_i),
    .push_valid_i(push_valid_o), .push_data_i(push_data_o), .push_ready_o(push_ready_i),
    .pop_valid_o(pop_valid_i), .pop_data_o(pop_data_i), .pop_ready_i(pop_ready_o),
    .overlap_o(overlap), .depth_o(depth));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // The clock runs at 125 MHz.
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  // Prints the verdict and ends the run.
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Compares a seen byte with the expected one.
  task automatic check(input byte_t seen, input byte_t exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Packs the three host flags as done, service, fault.
  function automatic byte_t flags();
    return {5'h0, command_done_o, service_request_o, fault_flag_o};
  endfunction

  // One host transfer: strobe once wait is low, hold it until wait rises.
  task automatic xfer(input logic cd, input logic rd, input byte_t d, output byte_t rq);
    int n;
    n = 0;
    @(negedge ref_clk_i);
    cmd_data_sel_i = cd;
    host_bus_i = d;
    while (wait_handshake_o !== 1'b0 && n < 50) begin
      @(negedge ref_clk_i);
      n++;
    end
    check({7'h0, wait_handshake_o}, 8'h00);
    if (rd) begin
      read_strobe_n_i = 1'b0;
    end else begin
      store_strobe_n_i = 1'b0;
    end
    n = 0;
    while (wait_handshake_o !== 1'b1 && n < 300) begin
      @(negedge ref_clk_i);
      n++;
    end
    check({7'h0, wait_handshake_o}, 8'h01);
    rq = host_bus_o;
    // The strobe stays low one more cycle, so the read data hold is exercised.
    @(negedge ref_clk_i);
    read_strobe_n_i = 1'b1;
    store_strobe_n_i = 1'b1;
    n = 0;
    while (wait_handshake_o !== 1'b0 && n < 50) begin
      @(negedge ref_clk_i);
      n++;
    end
    check({7'h0, wait_handshake_o}, 8'h00);
  endtask

  // Waits a bounded time for the done flag with no bus traffic that would clear it.
  task automatic wait_done();
    int n;
    n = 0;
    while (command_done_o !== 1'b1 && n < 200) begin
      @(negedge ref_clk_i);
      n++;
    end
    check({7'h0, command_done_o}, 8'h01);
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (6000) @(posedge ref_clk_i);
    n_mismatch++;
    tally_and_finish();
  end

  // Main sequence: table rows first, then the awkward cases.
  initial begin
    {resetn_i, chip_select_n_i, cmd_data_sel_i, stall} = 4'h0;
    {read_strobe_n_i, store_strobe_n_i, done_ack_n_i, service_ack_n_i} = 4'hf;
    host_bus_i = 8'h00;
    err_sel = 3'h0;
    n_mismatch = 0;
    n_tests = 0;
    repeat (6) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    resetn_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    check(flags(), 8'h00);
    foreach (rows[i]) begin
      xfer(rows[i].cd, rows[i].rd, rows[i].d, q);
      if (rows[i].rd) check(q, rows[i].exp);
    end
    err_sel = 3'h1;
    xfer(1'b1, 1'b0, 8'h84, q);
    check({1'b0, core_opcode_o}, 8'h04);
    wait_done();
    check(flags(), 8'h07);
    xfer(1'b1, 1'b1, 8'h00, q);
    check(q, 8'h29);
    check(flags(), 8'h02);
    service_ack_n_i = 1'b0;
    err_sel = 3'h0;
    repeat (6) @(negedge ref_clk_i);
    check(flags(), 8'h00);
    xfer(1'b1, 1'b0, 8'h81, q);
    wait_done();
    check(flags(), 8'h04);
    xfer(1'b0, 1'b0, 8'h77, q);
    check(flags(), 8'h00);
    service_ack_n_i = 1'b1;
    xfer(1'b1, 1'b0, 8'h01, q);
    wait_done();
    check(flags(), 8'h04);
    xfer(1'b0, 1'b1, 8'h00, q);
    check(q, 8'h77);
    check({7'h0, host_bus_oe_o}, 8'h00);
    xfer(1'b1, 1'b0, 8'h03, q);
    xfer(1'b1, 1'b0, 8'h04, q);
    xfer(1'b1, 1'b1, 8'h00, q);
    check(q, 8'ha8);
    check({7'h0, overlap}, 8'h00);
    xfer(1'b1, 1'b0, 8'h05, q);
    done_ack_n_i = 1'b0;
    k = 0;
    repeat (60) begin
      @(negedge ref_clk_i);
      if (command_done_o === 1'b1) k++;
    end
    check(k[7:0], 8'h01);
    done_ack_n_i = 1'b1;
    cmd_data_sel_i = 1'b0;
    chip_select_n_i = 1'b1;
    @(negedge ref_clk_i);
    store_strobe_n_i = 1'b0;
    repeat (10) @(negedge ref_clk_i);
    store_strobe_n_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    chip_select_n_i = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    check(depth[7:0], 8'h00);
    stall = 1'b1;
    xfer(1'b0, 1'b0, 8'h01, q);
    xfer(1'b0, 1'b0, 8'h02, q);
    fork
      xfer(1'b0, 1'b0, 8'h03, q);
      begin
        repeat (30) @(negedge ref_clk_i);
        check({7'h0, wait_handshake_o}, 8'h00);
        stall = 1'b0;
      end
    join
    repeat (4) @(negedge ref_clk_i);
    check(depth[7:0], 8'h03);
    for (k = 3; k > 0; k--) begin
      xfer(1'b0, 1'b1, 8'h00, q);
      check(q, k[7:0]);
    end
    err_sel = 3'h2;
    xfer(1'b1, 1'b0, 8'h82, q);
    wait_done();
    check(flags(), 8'h07);
    resetn_i = 1'b0;
    repeat (6) @(negedge ref_clk_i);
    check(flags(), 8'h00);
    resetn_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    xfer(1'b1, 1'b1, 8'h00, q);
    check(q, 8'h28);
    tally_and_finish();
  end
endmodule // fpu_host_bus_interface_tb_top
